// ### design/dcrvc_top.sv
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module dcrvc_top #(
  parameter int PERIOD_CYCLES = dcrvc_pkg::PERIOD_CYC,
  parameter int WINDOW_CYCLES = dcrvc_pkg::WINDOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] cpu1_voltage_code_bus,
  input wire logic [5:0] cpu2_voltage_code_bus,
  input wire logic cpu1_seventh_voltage_code_bit,
  input wire logic cpu2_seventh_voltage_code_bit,
  input wire logic [7:0] cpu1_core_rail_input,
  input wire logic [7:0] cpu2_core_rail_input,
  input wire logic [7:0] mid_scale_analog_input,
  input wire logic [7:0] quarter_scale_analog_input,
  output logic [7:0] mid_scale_temp,
  output logic [7:0] quarter_scale_temp,
  output logic irq
);
  import dcrvc_pkg::*;

  localparam int NSAMP = 1 << NSAMP_LOG;
  localparam int SAMP_CYC = (WINDOW_CYCLES / NSAMP > 0) ? WINDOW_CYCLES / NSAMP : 1;
  localparam int WIN_START = PERIOD_CYCLES - SAMP_CYC * NSAMP;
  localparam int PW = $clog2(PERIOD_CYCLES + 1);
  localparam int SW = $clog2(SAMP_CYC + 1);

  // filtered codes, bit 6 is the seventh pin
  logic [1:0][6:0] code;

  dcrvc_vid_filter u_filt1 (
    .clk(hclk),
    .rst_n(hresetn),
    .pin_code({cpu1_seventh_voltage_code_bit, cpu1_voltage_code_bus}),
    .stable_code(code[0])
  );

  dcrvc_vid_filter u_filt2 (
    .clk(hclk),
    .rst_n(hresetn),
    .pin_code({cpu2_seventh_voltage_code_bit, cpu2_voltage_code_bus}),
    .stable_code(code[1])
  );

  // software state
  dcrvc_ctrl_s ctrl;
  dcrvc_ctrl_s next_ctrl;
  logic [15:0] offs;
  logic [15:0] next_offs;
  logic [31:0] slim;
  logic [31:0] next_slim;
  logic [7:0] stat;
  logic [7:0] next_stat;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] addr_q;
  logic [7:0] next_addr_q;
  logic wr_q;
  logic next_wr_q;
  logic [31:0] next_hrdata;
  logic next_irq;
  // measurement state
  logic [PW-1:0] pcnt;
  logic [PW-1:0] next_pcnt;
  logic [SW-1:0] scnt;
  logic [SW-1:0] next_scnt;
  logic [1:0][ACC_W-1:0] acc;
  logic [1:0][ACC_W-1:0] next_acc;
  logic [1:0] skip;
  logic [1:0] next_skip;
  logic cmp_go;
  logic next_cmp_go;
  logic [1:0] gp;
  logic [1:0] next_gp;
  dcrvc_chk_s [1:0] chk;
  dcrvc_chk_s [1:0] next_chk;
  logic [7:0] next_mid;
  logic [7:0] next_quarter;
  // comparison terms
  logic in_win;
  logic smp;
  logic [7:0] ev;
  logic [1:0][7:0] rd;
  logic [1:0][15:0] rdq;
  logic [1:0][15:0] avg;
  logic [1:0][15:0] upper;
  logic [1:0][15:0] lowq;
  logic [1:0] updis;
  logic [1:0] dchk;
  logic ap;
  dcrvc_vid_s [1:0] dec;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd[0] = cpu1_core_rail_input;
  assign rd[1] = cpu2_core_rail_input;

  // decoded codes, kept in a net so no member is picked off a call result
  assign dec[0] = vid_decode(ctrl.mode, code[0]);
  assign dec[1] = vid_decode(ctrl.mode, code[1]);

  // limits and events for both rails, valid in the compare cycle
  always_comb
  begin
    ev = '0;
    for (int c = 0; c < 2; c++)
    begin
      rdq[c] = to_q(rd[c]);
      avg[c] = 16'(acc[c] >> NSAMP_LOG);
      upper[c] = avg[c] + to_q(offs[7:0]);
      lowq[c] = rdq[c] + to_q(offs[15:8]);
      updis[c] = upper[c] > CAP_Q;
      dchk[c] = cmp_go && ctrl.dyn_en && !skip[c];
      ev[c*ST_N+ST_DHI] = dchk[c] && !updis[c] && rdq[c] > upper[c];
      ev[c*ST_N+ST_DLO] = dchk[c] && lowq[c] < avg[c];
      // static checks use raw readings and ignore the dynamic path
      ev[c*ST_N+ST_SHI] = cmp_go && rd[c] > slim[c*16+:8];
      ev[c*ST_N+ST_SLO] = cmp_go && rd[c] < slim[c*16+8+:8];
    end
  end

  // period timer, sampling divider and code averaging
  always_comb
  begin
    in_win = pcnt >= PW'(WIN_START);
    smp = in_win && scnt == SW'(SAMP_CYC - 1);
    next_pcnt = (pcnt == PW'(PERIOD_CYCLES - 1)) ? '0 : pcnt + 1'b1;
    next_cmp_go = pcnt == PW'(PERIOD_CYCLES - 1);
    next_scnt = (!in_win || smp) ? '0 : scnt + 1'b1;
    next_acc = acc;
    next_skip = skip;
    next_chk = chk;
    next_gp = '0;
    next_mid = mid_scale_temp;
    next_quarter = quarter_scale_temp;
    if (cmp_go)
    begin
      next_acc = '0;
      next_skip = '0;
      for (int c = 0; c < 2; c++)
      begin
        next_chk[c].updis = updis[c];
        next_chk[c].skip = skip[c];
      end
      // signed form only when the input feeds fan control
      next_mid = {mid_scale_analog_input[7] ^ ctrl.temp_route,
                  mid_scale_analog_input[6:0]};
      next_quarter = {quarter_scale_analog_input[7] ^ ctrl.temp_route,
                      quarter_scale_analog_input[6:0]};
    end
    for (int c = 0; c < 2; c++)
    begin
      if (smp)
        next_acc[c] = next_acc[c] + ACC_W'(dec[c].volt);
      if (in_win && dec[c].off)
        next_skip[c] = 1'b1;
      if (ctrl.mode == SIX_BIT_CODE_MODE)
        next_gp[c] = code[c][6];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pcnt <= '0;
      scnt <= '0;
      acc <= '0;
      skip <= '0;
      cmp_go <= 1'b0;
      chk <= '0;
      gp <= '0;
      mid_scale_temp <= '0;
      quarter_scale_temp <= '0;
    end
    else
    begin
      pcnt <= next_pcnt;
      scnt <= next_scnt;
      acc <= next_acc;
      skip <= next_skip;
      cmp_go <= next_cmp_go;
      chk <= next_chk;
      gp <= next_gp;
      mid_scale_temp <= next_mid;
      quarter_scale_temp <= next_quarter;
    end
  end

  // bus slave, zero wait; read data comes from post-write values
  always_comb
  begin
    ap = hsel && htrans[1] && hready;
    next_addr_q = ap ? haddr[7:0] : addr_q;
    next_wr_q = ap && hwrite;
    next_ctrl = ctrl;
    next_offs = offs;
    next_slim = slim;
    next_mask = mask;
    next_stat = stat | ev;
    if (wr_q)
    begin
      case (addr_q)
        A_CTRL: next_ctrl = dcrvc_ctrl_s'(hwdata[3:0]);
        A_OFFS: next_offs = hwdata[15:0];
        A_SLIM: next_slim = hwdata;
        A_STAT: next_stat = (stat & ~hwdata[7:0]) | ev;
        A_MASK: next_mask = hwdata[7:0];
        default: next_mask = mask;
      endcase
    end
    next_hrdata = hrdata;
    if (ap && !hwrite)
    begin
      case (haddr[7:0])
        A_CTRL: next_hrdata = {28'h0000000, next_ctrl};
        A_OFFS: next_hrdata = {16'h0000, next_offs};
        A_SLIM: next_hrdata = next_slim;
        A_STAT: next_hrdata = {24'h000000, next_stat};
        A_MASK: next_hrdata = {24'h000000, next_mask};
        A_INFO: next_hrdata = {10'h000, chk[1].updis, chk[0].updis, chk[1].skip,
                               chk[0].skip, gp, 1'b0, code[1], 1'b0, code[0]};
        A_TEMP: next_hrdata = {16'h0000, quarter_scale_temp, mid_scale_temp};
        default: next_hrdata = 32'h00000000;
      endcase
    end
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= dcrvc_ctrl_s'(CTRL_RST);
      offs <= OFFS_RST;
      slim <= SLIM_RST;
      stat <= '0;
      mask <= '0;
      addr_q <= '0;
      wr_q <= 1'b0;
      hrdata <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      offs <= next_offs;
      slim <= next_slim;
      stat <= next_stat;
      mask <= next_mask;
      addr_q <= next_addr_q;
      wr_q <= next_wr_q;
      hrdata <= next_hrdata;
      irq <= next_irq;
    end
  end

  // checker helper: samples taken in the current window
  logic [NSAMP_LOG:0] nsmp;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      nsmp <= '0;
    else if (cmp_go)
      nsmp <= '0;
    else if (smp)
      nsmp <= nsmp + 1'b1;
  end

  AST_WINDOW_SAMPLES: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go |-> nsmp == (NSAMP_LOG + 1)'(NSAMP))
    else $error("window did not take the full sample count");

  AST_PERIOD_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go |=> !cmp_go [*8])
    else $error("compare cycles too close together");

  AST_EVENT_ONLY_AT_COMPARE: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat & ~$past(stat)) != 8'h00 |-> $past(cmp_go))
    else $error("status bit rose outside a compare cycle");

  AST_UPPER_EVENT: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && ctrl.dyn_en && !skip[0] && !updis[0] && rdq[0] > upper[0]
    |=> stat[ST_DHI])
    else $error("rail above upper limit not flagged");

  AST_LOWER_EVENT: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && ctrl.dyn_en && !skip[1] && lowq[1] < avg[1]
    |=> stat[ST_N+ST_DLO])
    else $error("rail below lower limit not flagged");

  AST_CAP_DISABLES_UPPER: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && upper[0] > CAP_Q |-> !ev[ST_DHI])
    else $error("upper check ran above the cap");

  AST_OFF_SKIPS: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && skip[1] |-> ev[ST_N+ST_DHI+:2] == 2'b00)
    else $error("dynamic check ran in an off window");

  AST_STATIC_INDEPENDENT: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && cpu1_core_rail_input > slim[7:0] |=> stat[ST_SHI])
    else $error("static high not flagged");

  AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    stat[ST_DLO] && !(wr_q && addr_q == A_STAT && hwdata[ST_DLO]) |=> stat[ST_DLO])
    else $error("sticky flag dropped without a clear");

  AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(stat & mask))
    else $error("interrupt level disagrees with masked status");

  COV_UPPER: cover property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && ev[ST_DHI]);
  COV_SKIP: cover property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && skip[0]);
  COV_CAP_LOWER: cover property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && updis[0] && ev[ST_DLO]);
  COV_STATIC_LOW: cover property (@(posedge hclk) disable iff (!hresetn)
    cmp_go && ev[ST_N+ST_SLO]);
endmodule

// ### design/dcrvc_pkg.sv
package dcrvc_pkg;
  // timing base
  localparam int CLK_MHZ = 100;
  localparam int PERIOD_MS = 100;
  localparam int PERIOD_CYC = PERIOD_MS * 1000 * CLK_MHZ;
  localparam int WINDOW_US = 1500;
  localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
  localparam int SKEW_NS = 400;
  localparam int SKEW_CYC = (SKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int SKEW_W = 6;
  localparam int NSAMP_LOG = 10;
  localparam int ACC_W = 24;
  // voltages are carried in quarter millivolts
  localparam logic [15:0] LSB_Q = 16'h0019; // one reading step, 6.25 mV
  localparam logic [15:0] CAP_Q = 16'h18CE; // 1.5875 V
  localparam logic [15:0] VBASE_Q = 16'h1900;
  localparam logic [15:0] VBASE_LOW_Q = 16'h1400;
  localparam logic [15:0] STEP_COARSE_Q = 16'h0032;
  localparam logic [15:0] STEP_FINE_Q = 16'h0019;
  localparam logic [5:0] OFF_CODE6 = 6'h3F;
  localparam logic [6:0] OFF_CODE7 = 7'h00;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OFFS = 8'h04;
  localparam logic [7:0] A_SLIM = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_INFO = 8'h14;
  localparam logic [7:0] A_TEMP = 8'h18;
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam logic [15:0] OFFS_RST = 16'h0808;
  localparam logic [31:0] SLIM_RST = 32'h00FF00FF;
  // status bit index inside one cpu group
  localparam int ST_DHI = 0;
  localparam int ST_DLO = 1;
  localparam int ST_SHI = 2;
  localparam int ST_SLO = 3;
  localparam int ST_N = 4;

  typedef enum logic [1:0] {
    SIX_BIT_CODE_MODE = 2'h0,
    EXTENDED_CODE_MODE = 2'h1,
    SEVEN_BIT_CODE_MODE = 2'h3,
    SEVEN_BIT_LOW_MODE = 2'h2
  } dcrvc_mode_e;
  typedef struct packed {
    logic temp_route;
    logic dyn_en;
    dcrvc_mode_e mode;
  } dcrvc_ctrl_s;
  typedef struct packed {
    logic off;
    logic [15:0] volt;
  } dcrvc_vid_s;
  typedef struct packed {
    logic updis;
    logic skip;
  } dcrvc_chk_s;

  function automatic logic [15:0] to_q(input logic [7:0] v);
    to_q = 16'({8'h00, v} * LSB_Q);
  endfunction

  function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
    sub_sat = (a > b) ? a - b : 16'h0000;
  endfunction

  // code to voltage per mode
  function automatic dcrvc_vid_s vid_decode(input dcrvc_mode_e m, input logic [6:0] c);
    dcrvc_vid_s r;
    r = '0;
    case (m)
      SIX_BIT_CODE_MODE:
      begin
        r.off = c[5:0] == OFF_CODE6;
        r.volt = sub_sat(VBASE_Q, 16'({10'h000, c[5:0]} * STEP_COARSE_Q));
      end
      EXTENDED_CODE_MODE:
      begin
        r.off = c[5:0] == OFF_CODE6;
        r.volt = sub_sat(VBASE_Q, 16'({10'h000, c[5:0]} * STEP_COARSE_Q)
                 + (c[6] ? STEP_FINE_Q : 16'h0000));
      end
      SEVEN_BIT_CODE_MODE:
      begin
        r.off = c == OFF_CODE7;
        r.volt = sub_sat(VBASE_Q, 16'({9'h000, c} * STEP_FINE_Q));
      end
      default:
      begin
        r.off = c == OFF_CODE7;
        r.volt = sub_sat(VBASE_LOW_Q, 16'({9'h000, c} * STEP_FINE_Q));
      end
    endcase
    vid_decode = r;
  endfunction
endpackage

// ### design/dcrvc_vid_filter.sv
`timescale 1ns/1ps
module dcrvc_vid_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] pin_code,
  output logic [6:0] stable_code
);
  import dcrvc_pkg::*;

  logic [6:0] meta;
  logic [6:0] sync;
  logic [6:0] last;
  logic [6:0] next_code;
  logic [SKEW_W-1:0] cnt;
  logic [SKEW_W-1:0] next_cnt;

  // a code counts only after standing still for the skew time;
  // the skew time is far below the fastest legal code change
  always_comb
  begin
    next_cnt = cnt;
    next_code = stable_code;
    if (sync != last)
      next_cnt = '0;
    else if (cnt == SKEW_W'(SKEW_CYC - 1))
      next_code = sync;
    else
      next_cnt = cnt + 1'b1;
  end

  // pins pass two flops before anything reads them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync <= '0;
      last <= '0;
      cnt <= '0;
      stable_code <= '0;
    end
    else
    begin
      meta <= pin_code;
      sync <= meta;
      last <= sync;
      cnt <= next_cnt;
      stable_code <= next_code;
    end
  end
endmodule

// ### dv/dcrvc_cpu_model.sv
`timescale 1ns/1ps
module dcrvc_cpu_model #(
  parameter int GAP = 500
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic jump,
  input wire logic [6:0] target,
  input wire logic [7:0] rail,
  output logic [5:0] code_bus,
  output logic code_b6,
  output logic [7:0] rail_out
);
  int gap_cnt;
  logic [6:0] code;
  // all code bits move together, no skew modelled
  assign code_bus = code[5:0];
  assign code_b6 = code[6];
  // regulator settles at once, so the reading follows the requested rail
  assign rail_out = rail;
  // one code change per gap; ramps step one lsb, jumps model a program change
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code <= 7'h00;
      gap_cnt <= 0;
    end
    else if (gap_cnt < GAP - 1)
      gap_cnt <= gap_cnt + 1;
    else if (code != target)
    begin
      gap_cnt <= 0;
      code <= jump ? target : (code < target ? code + 7'h01 : code - 7'h01);
    end
  end
endmodule

// ### dv/dynamic_core_rail_vid_checker_tb_top.sv
`timescale 1ns/1ps
module dynamic_core_rail_vid_checker_tb_top;
  import dcrvc_pkg::*;
  localparam int P = 8000;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [6:0] c1;
    logic [6:0] c2;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [15:0] offs;
    logic [7:0] stat;
    logic [3:0] flg;
  } dcrvc_row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic jmp = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0] t1 = 7'h00;
  logic [6:0] t2 = 7'h00;
  logic [7:0] rl1 = 8'h00;
  logic [7:0] rl2 = 8'h00;
  logic [7:0] mid = 8'h00;
  logic [7:0] quart = 8'hD8;
  logic hready, hreadyout, hresp, irq, b61, b62;
  logic [31:0] hrdata;
  logic [5:0] bus1, bus2;
  logic [7:0] ad1, ad2, mtemp, qtemp, me;
  int cyc = 0;
  int nxt = 0;
  int failures = 0;
  int check_count = 0;
  dcrvc_row_s r;
  // rows: ctrl, code1, code2, rail1, rail2, offsets, status, {updis, skip}
  dcrvc_row_s rows [8] = '{
    '{4'hC, 7'h50, 7'h10, 8'hE9, 8'hD7, 16'h0808, 8'h21, 4'h0},
    '{4'h4, 7'h10, 7'h10, 8'hE8, 8'hD8, 16'h0808, 8'h00, 4'h0},
    '{4'h4, 7'h00, 7'h00, 8'hFF, 8'h64, 16'h0808, 8'h20, 4'hC},
    '{4'h4, 7'h3F, 7'h10, 8'h00, 8'hE9, 16'h0808, 8'h10, 4'h1},
    '{4'h5, 7'h50, 7'h10, 8'hE8, 8'hE8, 16'h0808, 8'h01, 4'h0},
    '{4'h7, 7'h20, 7'h00, 8'hD7, 8'h00, 16'h0808, 8'h02, 4'hA},
    '{4'h6, 7'h10, 7'h10, 8'hBF, 8'hB8, 16'h0402, 8'h21, 4'h0},
    '{4'h3, 7'h20, 7'h20, 8'h00, 8'h00, 16'h0808, 8'h00, 4'h0}
  };
  logic [7:0] ra [6] = '{A_CTRL, A_OFFS, A_SLIM, A_STAT, A_MASK, 8'h1C};
  logic [31:0] rv [6] = '{32'h4, 32'h0808, 32'h00FF00FF, 32'h0, 32'h0, 32'h0};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  dcrvc_top #(.PERIOD_CYCLES(P), .WINDOW_CYCLES(2048)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu1_voltage_code_bus(bus1), .cpu2_voltage_code_bus(bus2),
    .cpu1_seventh_voltage_code_bit(b61), .cpu2_seventh_voltage_code_bit(b62),
    .cpu1_core_rail_input(ad1), .cpu2_core_rail_input(ad2),
    .mid_scale_analog_input(mid), .quarter_scale_analog_input(quart),
    .mid_scale_temp(mtemp), .quarter_scale_temp(qtemp), .irq(irq));
  dcrvc_cpu_model CPU1 (.clk(hclk), .rst_n(hresetn), .jump(jmp), .target(t1), .rail(rl1),
    .code_bus(bus1), .code_b6(b61), .rail_out(ad1));
  dcrvc_cpu_model CPU2 (.clk(hclk), .rst_n(hresetn), .jump(jmp), .target(t2), .rail(rl2),
    .code_bus(bus2), .code_b6(b62), .rail_out(ad2));

  // clock and a cycle count since reset release, which paces the periods
  initial
  begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= hresetn ? cyc + 1 : 0;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer: address phase, then data phase, each held until ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask

  task automatic setup(input dcrvc_row_s s);
    wr(A_CTRL, {28'h0, s.ctrl});
    wr(A_OFFS, {16'h0, s.offs});
    wr(A_STAT, 32'hFF);
    t1 <= s.c1;
    t2 <= s.c2;
    rl1 <= s.r1;
    rl2 <= s.r2;
  endtask

  // results stand a little after the compare cycle
  task automatic to_cmp();
    nxt += P;
    while (cyc < nxt + 60) @(posedge hclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ten periods of work, cut short well after them
  initial
  begin
    #950us;
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge hclk);
    chk("rst_hrdata", hrdata, 32'h0);
    chk("rst_irq", {31'h0, irq}, 32'h0);
    chk("rst_bus_resp", {30'h0, hresp, hreadyout}, 32'h1);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++)
      rdc("reset_value", ra[i], rv[i]);
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      mid <= 8'h21 + 8'(i);
      setup(r);
      to_cmp();
      me = r.ctrl[3] ? {~mid[7], mid[6:0]} : mid;
      rdc("stat", A_STAT, {24'h0, r.stat});
      rdc("info", A_INFO, {10'h0, r.flg, (r.ctrl[1:0] == 2'h0) ? {r.c2[6], r.c1[6]} : 2'h0,
        1'b0, r.c2, 1'b0, r.c1});
      rdc("temp", A_TEMP, {16'h0, r.ctrl[3] ? 8'h58 : 8'hD8, me});
      chk("temp_pin", {16'h0, qtemp, mtemp}, {16'h0, r.ctrl[3] ? 8'h58 : 8'hD8, me});
      chk("bus_resp", {30'h0, hresp, hreadyout}, 32'h1);
    end
    // ramp across the window: the average stays inside, the final code would not
    wr(A_MASK, 32'h01);
    setup('{4'h4, 7'h10, 7'h10, 8'hE2, 8'hE2, 16'h0808, 8'h00, 4'h0});
    while (cyc < nxt + P - 2048) @(posedge hclk);
    jmp <= 1'b0;
    t1 <= 7'h14;
    t2 <= 7'h14;
    to_cmp();
    rdc("avg_stat", A_STAT, 32'h0);
    // same rails against the settled code, with static limits that also trip
    wr(A_SLIM, 32'hF0FF00D0);
    to_cmp();
    chk("irq_set", {31'h0, irq}, 32'h1);
    rdc("both_stat", A_STAT, 32'h95);
    rdc("stat_kept", A_STAT, 32'h95);
    wr(A_STAT, 32'h01);
    repeat (3) @(posedge hclk);
    #1;
    chk("irq_clr", {31'h0, irq}, 32'h0);
    rdc("stat_w1c", A_STAT, 32'h94);
    wrap_up();
  end
endmodule
